// [hw/cduc_pkg.sv]
`default_nettype none
package cduc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_GAIN      = 8'h23;
	localparam logic [7:0] ADDR_UNUSED_A  = 8'h24;
	localparam logic [7:0] ADDR_UNUSED_B  = 8'h25;
	localparam logic [7:0] ADDR_REF_WAIT  = 8'h26;
	localparam logic [7:0] ADDR_PULSE_SEL = 8'h27;
	localparam logic [7:0] ADDR_CAP_SEL   = 8'h28;
	localparam logic [7:0] ADDR_RES_SEL   = 8'h29;
	localparam logic [7:0] ADDR_ALARM     = 8'h2a;
	localparam logic [7:0] ADDR_RUN       = 8'h2f;
	localparam logic [7:0] ADDR_LOCK      = 8'h30;
	localparam logic [7:0] ADDR_SER_LO    = 8'h31;
	localparam logic [7:0] ADDR_SER_HI    = 8'h32;
	localparam logic [7:0] ADDR_INT0      = 8'h33;
	localparam logic [7:0] ADDR_INT1      = 8'h34;
	localparam logic [7:0] ADDR_INT2      = 8'h35;
	// field positions
	localparam int PULSE1_LSB  = 4;
	localparam int PULSE0_LSB  = 0;
	localparam int SEL_W       = 4;
	localparam int ALARM_B_BIT = 6;
	localparam int ALARM_A_BIT = 4;
	localparam int UPD_HS_BIT  = 3;
	localparam int FAST_BIT    = 2;
	localparam int R_MED_BIT   = 1;
	localparam int C_MED_BIT   = 0;
	localparam int RUN_POS     = 0;
	localparam int LOCK_W      = 4;
	localparam logic [7:0] ALARM_USED_MASK = 8'h5f;
	// reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [8:0]  GAIN_ZERO = 9'h000;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	// nvm word region bounds: 703, 831, 959, 1007, 1022
	localparam logic [9:0] NVM_R0_END = 10'h2bf;
	localparam logic [9:0] NVM_R1_END = 10'h33f;
	localparam logic [9:0] NVM_R2_END = 10'h3bf;
	localparam logic [9:0] NVM_R3_END = 10'h3ef;
	localparam logic [9:0] NVM_R3_TOP = 10'h3fe;
endpackage : cduc_pkg
`default_nettype wire

// [hw/cduc_result_slot.sv]
`timescale 1ns/1ps
`default_nettype none
module cduc_result_slot
	import cduc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// control
	input  wire logic        hs_en_i,
	input  wire logic        load_i,
	input  wire logic [31:0] data_i,
	input  wire logic        read_i,
	// state
	output var  logic [31:0] value_o,
	output var  logic        unread_o
);
	typedef struct packed {
		logic [31:0] value;
		logic        unread;
	} cduc_slot_type;

	cduc_slot_type st_ff;
	cduc_slot_type nxt_st;
	logic          store;

	always_comb begin
		nxt_st = st_ff;
		// a read in the same cycle frees the slot
		store = load_i && (!hs_en_i || !st_ff.unread || read_i);
		if (store) begin
			nxt_st.value  = data_i;
			nxt_st.unread = 1'b1;
		end else if (read_i) begin
			nxt_st.unread = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '{value: RST_WORD, unread: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign value_o  = st_ff.value;
	assign unread_o = st_ff.unread;

	a_hold_unread: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hs_en_i && unread_o && !read_i |=> $stable(value_o))
		else $error("unread result overwritten");
endmodule : cduc_result_slot
`default_nettype wire

// [hw/cduc_once_byte.sv]
`timescale 1ns/1ps
`default_nettype none
module cduc_once_byte
	import cduc_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// write and erase
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       erase_i,
	// stored byte
	output var  logic [7:0] value_o
);
	typedef struct packed {
		logic [7:0] value;
	} cduc_once_type;

	cduc_once_type st_ff;
	cduc_once_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (erase_i) begin
			nxt_st.value = RST_BYTE;
		end else if (wr_i && (st_ff.value == RST_BYTE)) begin
			nxt_st.value = wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '{value: RST_BYTE};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign value_o = st_ff.value;

	a_serial_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(value_o != 8'h00) && !erase_i |=> $stable(value_o))
		else $error("serial byte rewritten");
endmodule : cduc_once_byte
`default_nettype wire

// [hw/cduc_cfg_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module cduc_cfg_bank
	import cduc_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_b_i,
	// host register port
	input  wire logic             cfg_wr_i,
	input  wire logic             cfg_rd_i,
	input  wire logic [7:0]       cfg_addr_i,
	input  wire logic [7:0]       cfg_wdata_i,
	output var  logic [7:0]       cfg_rdata_o,
	output var  logic             cfg_rvalid_o,
	// nvm erase and access check
	input  wire logic             nvm_erase_i,
	input  wire logic             nvm_req_i,
	input  wire logic [9:0]       nvm_addr_i,
	output var  logic             nvm_grant_o,
	output var  logic             nvm_block_o,
	// result words
	input  wire logic [7:0]       res_load_i,
	input  wire logic [7:0][31:0] res_data_i,
	input  wire logic             res_rd_i,
	input  wire logic [2:0]       res_idx_i,
	output var  logic [31:0]      res_rdata_o,
	output var  logic             res_rvalid_o,
	output var  logic [7:0]       res_unread_o,
	// pulse interfaces
	output var  logic [31:0]      pulse_if0_data_o,
	output var  logic [31:0]      pulse_if1_data_o,
	// firmware settings
	output var  logic [8:0]       gain_correction_factor_o,
	output var  logic [7:0]       reference_wait_time_o,
	output var  logic [7:0]       cap_ratio_sel_o,
	output var  logic [7:0]       res_ratio_sel_o,
	output var  logic             alarm_a_source_o,
	output var  logic             alarm_b_source_o,
	output var  logic             r_median_en_o,
	output var  logic             c_median_en_o,
	output var  logic             update_after_read_enable_o,
	output var  logic             fast_mode_select_o,
	output var  logic             run_protect_switch_o,
	output var  logic [3:0]       nvm_lock_mask_o,
	output var  logic [15:0]      serial_id_o
);
	typedef struct packed {
		logic [7:0]  gain;
		logic [8:0]  gain_fac;
		logic [7:0]  ref_wait;
		logic [7:0]  pulse_sel;
		logic [7:0]  cap_sel;
		logic [7:0]  res_sel;
		logic [7:0]  alarm;
		logic        run;
		logic [3:0]  lock;
		logic [7:0]  int0;
		logic [7:0]  int1;
		logic [7:0]  int2;
		logic [7:0]  rdata;
		logic        rvalid;
		logic [31:0] res_rdata;
		logic        res_rvalid;
		logic [31:0] pulse0;
		logic [31:0] pulse1;
		logic        grant;
		logic        block;
	} cduc_bank_type;

	localparam cduc_bank_type BANK_RST = '{
		gain: RST_BYTE, gain_fac: GAIN_ZERO, ref_wait: RST_BYTE,
		pulse_sel: RST_BYTE, cap_sel: RST_BYTE, res_sel: RST_BYTE,
		alarm: RST_BYTE, run: 1'b0, lock: 4'h0, int0: RST_BYTE,
		int1: RST_BYTE, int2: RST_BYTE, rdata: RST_BYTE, rvalid: 1'b0,
		res_rdata: RST_WORD, res_rvalid: 1'b0, pulse0: RST_WORD,
		pulse1: RST_WORD, grant: 1'b0, block: 1'b0};

	logic              rst_meta_ff;
	logic              rst_n;
	cduc_bank_type     st_ff;
	cduc_bank_type     nxt_st;
	logic [7:0][31:0]  slot_val;
	logic [7:0]        slot_unread;
	logic [7:0]        slot_read;
	logic [7:0]        slot_load;
	logic [7:0]        ser_lo;
	logic [7:0]        ser_hi;
	logic [7:0]        rd_mux;
	logic [3:0]        sel0;
	logic [3:0]        sel1;
	logic [3:0]        region_hit;

	// reset release through two flops
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	assign sel0 = st_ff.pulse_sel[PULSE0_LSB +: SEL_W];
	assign sel1 = st_ff.pulse_sel[PULSE1_LSB +: SEL_W];

	// result slots, loads held off while idle
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_slot
			assign slot_read[gi] = res_rd_i && (res_idx_i == 3'(gi));
			assign slot_load[gi] = res_load_i[gi] && st_ff.run;
			cduc_result_slot u_slot (
				.clk_i    (ref_clk_i),
				.rst_n_i  (rst_n),
				.hs_en_i  (st_ff.alarm[UPD_HS_BIT]),
				.load_i   (slot_load[gi]),
				.data_i   (res_data_i[gi]),
				.read_i   (slot_read[gi]),
				.value_o  (slot_val[gi]),
				.unread_o (slot_unread[gi])
			);
		end
	endgenerate

	// serial id bytes
	cduc_once_byte u_ser_lo (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.wr_i    (cfg_wr_i && (cfg_addr_i == ADDR_SER_LO)),
		.wdata_i (cfg_wdata_i),
		.erase_i (nvm_erase_i),
		.value_o (ser_lo)
	);

	cduc_once_byte u_ser_hi (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.wr_i    (cfg_wr_i && (cfg_addr_i == ADDR_SER_HI)),
		.wdata_i (cfg_wdata_i),
		.erase_i (nvm_erase_i),
		.value_o (ser_hi)
	);

	// nvm region decode
	always_comb begin
		region_hit = 4'h0;
		if (nvm_addr_i <= NVM_R0_END) begin
			region_hit[0] = 1'b1;
		end else if (nvm_addr_i <= NVM_R1_END) begin
			region_hit[1] = 1'b1;
		end else if (nvm_addr_i <= NVM_R2_END) begin
			region_hit[2] = 1'b1;
		end else if (nvm_addr_i <= NVM_R3_END || nvm_addr_i >= NVM_R3_TOP) begin
			region_hit[3] = 1'b1;
		end
	end

	// register read mux, unused locations read zero
	always_comb begin
		case (cfg_addr_i)
			ADDR_GAIN:      rd_mux = st_ff.gain;
			ADDR_REF_WAIT:  rd_mux = st_ff.ref_wait;
			ADDR_PULSE_SEL: rd_mux = st_ff.pulse_sel;
			ADDR_CAP_SEL:   rd_mux = st_ff.cap_sel;
			ADDR_RES_SEL:   rd_mux = st_ff.res_sel;
			ADDR_ALARM:     rd_mux = st_ff.alarm;
			ADDR_RUN:       rd_mux = {7'h00, st_ff.run};
			ADDR_LOCK:      rd_mux = {4'h0, st_ff.lock};
			ADDR_SER_LO:    rd_mux = ser_lo;
			ADDR_SER_HI:    rd_mux = ser_hi;
			ADDR_INT0:      rd_mux = st_ff.int0;
			ADDR_INT1:      rd_mux = st_ff.int1;
			ADDR_INT2:      rd_mux = st_ff.int2;
			default:        rd_mux = RST_BYTE;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		if (cfg_wr_i) begin
			case (cfg_addr_i)
				ADDR_GAIN: begin
					nxt_st.gain = cfg_wdata_i;
					// 1.8 fixed point: zero, else 256 + n
					nxt_st.gain_fac = (cfg_wdata_i == RST_BYTE) ? GAIN_ZERO : {1'b1, cfg_wdata_i};
				end
				ADDR_REF_WAIT: begin
					nxt_st.ref_wait = cfg_wdata_i;
				end
				ADDR_PULSE_SEL: begin
					nxt_st.pulse_sel = cfg_wdata_i;
				end
				ADDR_CAP_SEL: begin
					nxt_st.cap_sel = cfg_wdata_i;
				end
				ADDR_RES_SEL: begin
					nxt_st.res_sel = cfg_wdata_i;
				end
				ADDR_ALARM: begin
					nxt_st.alarm = cfg_wdata_i & ALARM_USED_MASK;
				end
				ADDR_RUN: begin
					nxt_st.run = cfg_wdata_i[RUN_POS];
				end
				ADDR_LOCK: begin
					nxt_st.lock = cfg_wdata_i[LOCK_W-1:0];
				end
				ADDR_INT0: begin
					nxt_st.int0 = cfg_wdata_i;
				end
				ADDR_INT1: begin
					nxt_st.int1 = cfg_wdata_i;
				end
				ADDR_INT2: begin
					nxt_st.int2 = cfg_wdata_i;
				end
				default: begin
				end
			endcase
		end
		nxt_st.rvalid = cfg_rd_i;
		if (cfg_rd_i) begin
			nxt_st.rdata = rd_mux;
		end
		nxt_st.res_rvalid = res_rd_i;
		if (res_rd_i) begin
			nxt_st.res_rdata = slot_val[res_idx_i];
		end
		// codes 8 to 15 drive zero
		nxt_st.pulse0 = sel0[3] ? RST_WORD : slot_val[sel0[2:0]];
		nxt_st.pulse1 = sel1[3] ? RST_WORD : slot_val[sel1[2:0]];
		nxt_st.block = nvm_req_i && |(region_hit & st_ff.lock);
		nxt_st.grant = nvm_req_i && !(|(region_hit & st_ff.lock));
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= BANK_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cfg_rdata_o                = st_ff.rdata;
	assign cfg_rvalid_o               = st_ff.rvalid;
	assign nvm_grant_o                = st_ff.grant;
	assign nvm_block_o                = st_ff.block;
	assign res_rdata_o                = st_ff.res_rdata;
	assign res_rvalid_o               = st_ff.res_rvalid;
	assign res_unread_o               = slot_unread;
	assign pulse_if0_data_o           = st_ff.pulse0;
	assign pulse_if1_data_o           = st_ff.pulse1;
	assign gain_correction_factor_o   = st_ff.gain_fac;
	assign reference_wait_time_o      = st_ff.ref_wait;
	assign cap_ratio_sel_o            = st_ff.cap_sel;
	assign res_ratio_sel_o            = st_ff.res_sel;
	assign alarm_a_source_o           = st_ff.alarm[ALARM_A_BIT];
	assign alarm_b_source_o           = st_ff.alarm[ALARM_B_BIT];
	assign r_median_en_o              = st_ff.alarm[R_MED_BIT];
	assign c_median_en_o              = st_ff.alarm[C_MED_BIT];
	assign update_after_read_enable_o = st_ff.alarm[UPD_HS_BIT];
	assign fast_mode_select_o         = st_ff.alarm[FAST_BIT];
	assign run_protect_switch_o       = st_ff.run;
	assign nvm_lock_mask_o            = st_ff.lock;
	assign serial_id_o                = {ser_hi, ser_lo};

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n);

	a_gain_factor: assert property (
		cfg_wr_i && cfg_addr_i == ADDR_GAIN |=> gain_correction_factor_o ==
		(($past(cfg_wdata_i) == 8'h00) ? 9'h000 : (9'h100 + {1'b0, $past(cfg_wdata_i)})))
		else $error("gain factor wrong");

	a_pulse_source: assert property (
		!sel0[3] |=> pulse_if0_data_o == $past(slot_val[sel0[2:0]]))
		else $error("pulse 0 source wrong");

	a_pulse1_source: assert property (
		!sel1[3] |=> pulse_if1_data_o == $past(slot_val[sel1[2:0]]))
		else $error("pulse 1 source wrong");

	a_pulse0_high_code: assert property (
		sel0[3] |=> pulse_if0_data_o == 32'h0)
		else $error("pulse 0 not zero for code above 7");

	a_pulse_high_code: assert property (
		sel1[3] |=> pulse_if1_data_o == 32'h0)
		else $error("pulse 1 not zero for code above 7");

	a_cap_select: assert property (
		cfg_wr_i && cfg_addr_i == ADDR_CAP_SEL |=> cap_ratio_sel_o == $past(cfg_wdata_i))
		else $error("cap ratio select not stored");

	a_res_select: assert property (
		cfg_wr_i && cfg_addr_i == ADDR_RES_SEL |=> res_ratio_sel_o == $past(cfg_wdata_i))
		else $error("res ratio select not stored");

	a_alarm_median: assert property (
		cfg_wr_i && cfg_addr_i == ADDR_ALARM |=> alarm_b_source_o == $past(cfg_wdata_i[6])
		&& alarm_a_source_o == $past(cfg_wdata_i[4]) && r_median_en_o == $past(cfg_wdata_i[1])
		&& c_median_en_o == $past(cfg_wdata_i[0]))
		else $error("alarm or median bits not stored");

	a_median_enable: assert property (
		cfg_wr_i && cfg_addr_i == ADDR_ALARM |=> r_median_en_o == $past(cfg_wdata_i[R_MED_BIT])
		&& c_median_en_o == $past(cfg_wdata_i[C_MED_BIT]))
		else $error("median enables not stored");

	a_run_idle: assert property (
		!run_protect_switch_o |=> $stable(slot_val))
		else $error("result changed while idle");

	a_lock_region: assert property (
		nvm_req_i && nvm_lock_mask_o[3] && nvm_addr_i >= 10'h3fe |=> nvm_block_o && !nvm_grant_o)
		else $error("locked top region not blocked");

	a_lock_free: assert property (
		nvm_req_i && nvm_lock_mask_o == 4'h0 |=> nvm_grant_o && !nvm_block_o)
		else $error("unlocked access blocked");

	a_unused_zero: assert property (
		cfg_rd_i && (cfg_addr_i == ADDR_UNUSED_A || cfg_addr_i == ADDR_UNUSED_B)
		|=> cfg_rvalid_o && cfg_rdata_o == 8'h00)
		else $error("unused byte reads nonzero");

	a_unused_write: assert property (
		cfg_wr_i && (cfg_addr_i == ADDR_UNUSED_A || cfg_addr_i == ADDR_UNUSED_B)
		|=> $stable(gain_correction_factor_o) && $stable(reference_wait_time_o) && $stable(nvm_lock_mask_o))
		else $error("unused byte write took effect");
endmodule : cduc_cfg_bank
`default_nettype wire

// [sim/cduc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cduc_host_model
	import cduc_pkg::*;
(
	// clock
	input  wire logic       clk_i,
	// register port
	output var  logic       wr_o,
	output var  logic       rd_o,
	output var  logic [7:0] addr_o,
	output var  logic [7:0] wdata_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	logic run_on = 1'b0;

	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end

	// one strobe; lines inverted once released
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
		if (a == ADDR_RUN) run_on = d[RUN_POS];
	endtask : put

	task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a >= ADDR_INT0 && a <= ADDR_INT2) v = 8'h00;
		if (a == ADDR_ALARM) v[FAST_BIT] = 1'b0;
		if (run_on && a != ADDR_RUN) put(ADDR_RUN, 8'h00);
		put(a, v);
	endtask : cfg_write

	task automatic cfg_read(input logic [7:0] a, output logic [7:0] v, output logic ok);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		ok = 1'b0;
		v = 8'h00;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (rvalid_i === 1'b1) begin
				ok = 1'b1;
				v = rdata_i;
			end else begin
				@(posedge clk_i);
			end
		end
	endtask : cfg_read
endmodule : cduc_host_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
	import cduc_pkg::*;
;
	logic             ref_clk_i, rst_b_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o, nvm_erase_i, nvm_req_i;
	logic             nvm_grant_o, nvm_block_o, res_rd_i, res_rvalid_o, alarm_a_source_o, alarm_b_source_o;
	logic             r_median_en_o, c_median_en_o, update_after_read_enable_o, fast_mode_select_o;
	logic             run_protect_switch_o;
	logic [7:0]       cfg_addr_i, cfg_wdata_i, cfg_rdata_o, res_load_i, res_unread_o;
	logic [7:0]       reference_wait_time_o, cap_ratio_sel_o, res_ratio_sel_o;
	logic [9:0]       nvm_addr_i;
	logic [7:0][31:0] res_data_i;
	logic [2:0]       res_idx_i;
	logic [31:0]      res_rdata_o, pulse_if0_data_o, pulse_if1_data_o;
	logic [8:0]       gain_correction_factor_o;
	logic [3:0]       nvm_lock_mask_o;
	logic [15:0]      serial_id_o;
	logic [7:0]       exp_r [256];
	logic [31:0]      slot [8];
	logic [7:0]       unrd;
	int               failures, n_tests;
	int               nb [12] = '{0, 703, 704, 831, 832, 959, 960, 1007, 1008, 1021, 1022, 1023};

	cduc_cfg_bank u_cduc_cfg_bank (
		.ref_clk_i, .rst_b_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o,
		.nvm_erase_i, .nvm_req_i, .nvm_addr_i, .nvm_grant_o, .nvm_block_o, .res_load_i, .res_data_i,
		.res_rd_i, .res_idx_i, .res_rdata_o, .res_rvalid_o, .res_unread_o, .pulse_if0_data_o,
		.pulse_if1_data_o, .gain_correction_factor_o, .reference_wait_time_o, .cap_ratio_sel_o,
		.res_ratio_sel_o, .alarm_a_source_o, .alarm_b_source_o, .r_median_en_o, .c_median_en_o,
		.update_after_read_enable_o, .fast_mode_select_o, .run_protect_switch_o, .nvm_lock_mask_o,
		.serial_id_o
	);

	cduc_host_model u_cduc_host_model (
		.clk_i   (ref_clk_i),
		.wr_o    (cfg_wr_i),
		.rd_o    (cfg_rd_i),
		.addr_o  (cfg_addr_i),
		.wdata_o (cfg_wdata_i),
		.rdata_i (cfg_rdata_o),
		.rvalid_i(cfg_rvalid_o)
	);

	task automatic results();
		if (failures == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h got %h", n, e, g);
		end
	endtask : chk

	task automatic outs();
		logic [7:0] o;
		o = exp_r[ADDR_ALARM];
		chk("gain", (exp_r[ADDR_GAIN] == 8'h00) ? 32'h0 : 32'h100 + 32'(exp_r[ADDR_GAIN]),
			32'(gain_correction_factor_o));
		chk("sel", 32'({exp_r[ADDR_REF_WAIT], exp_r[ADDR_CAP_SEL], exp_r[ADDR_RES_SEL]}),
			32'({reference_wait_time_o, cap_ratio_sel_o, res_ratio_sel_o}));
		chk("opt", 32'({o[6], o[4], o[3], o[2], o[1], o[0]}), 32'({alarm_b_source_o, alarm_a_source_o,
			update_after_read_enable_o, fast_mode_select_o, r_median_en_o, c_median_en_o}));
		chk("run", 32'(exp_r[ADDR_RUN]), 32'(run_protect_switch_o));
		chk("lock", 32'(exp_r[ADDR_LOCK]), 32'(nvm_lock_mask_o));
		chk("serial", 32'({exp_r[ADDR_SER_HI], exp_r[ADDR_SER_LO]}), 32'(serial_id_o));
	endtask : outs

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_cduc_host_model.cfg_write(a, d);
		if (a != ADDR_RUN) exp_r[ADDR_RUN] = 8'h00;
		case (a)
			ADDR_GAIN, ADDR_REF_WAIT, ADDR_PULSE_SEL, ADDR_CAP_SEL, ADDR_RES_SEL: exp_r[a] = d;
			ADDR_ALARM: exp_r[a] = d & 8'h5b;
			ADDR_RUN: exp_r[a] = d & 8'h01;
			ADDR_LOCK: exp_r[a] = d & 8'h0f;
			ADDR_SER_LO, ADDR_SER_HI: if (exp_r[a] == 8'h00) exp_r[a] = d;
			default: ;
		endcase
		repeat (2) @(posedge ref_clk_i);
		#1;
		outs();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic [7:0] v;
		logic       ok;
		u_cduc_host_model.cfg_read(a, v, ok);
		if (!ok) begin
			chk("cfg_rvalid", 32'h1, 32'h0);
			results();
		end
		chk("cfg_rdata", 32'(exp_r[a]), 32'(v));
	endtask : rd

	task automatic load(input int i, input logic [31:0] d);
		@(posedge ref_clk_i);
		res_load_i <= 8'(1 << i);
		res_data_i[i] <= d;
		@(posedge ref_clk_i);
		res_load_i <= 8'h00;
		res_data_i[i] <= ~d;
		if (exp_r[ADDR_RUN][0] && (!exp_r[ADDR_ALARM][3] || !unrd[i])) begin
			slot[i] = d;
			unrd[i] = 1'b1;
		end
		#1;
		chk("unread", 32'(unrd), 32'(res_unread_o));
	endtask : load

	task automatic rres(input int i);
		@(posedge ref_clk_i);
		res_rd_i <= 1'b1;
		res_idx_i <= 3'(i);
		@(posedge ref_clk_i);
		res_rd_i <= 1'b0;
		res_idx_i <= 3'(~i);
		unrd[i] = 1'b0;
		#1;
		chk("res_rvalid", 32'h1, 32'(res_rvalid_o));
		chk("res_rdata", slot[i], res_rdata_o);
		chk("unread", 32'(unrd), 32'(res_unread_o));
	endtask : rres

	task automatic nvm(input int a);
		logic b;
		int   r;
		@(posedge ref_clk_i);
		nvm_req_i <= 1'b1;
		nvm_addr_i <= 10'(a);
		@(posedge ref_clk_i);
		nvm_req_i <= 1'b0;
		nvm_addr_i <= 10'(~a);
		r = (a <= 703) ? 0 : (a <= 831) ? 1 : (a <= 959) ? 2 : (a <= 1007 || a >= 1022) ? 3 : 4;
		b = (r < 4) && exp_r[ADDR_LOCK][r];
		#1;
		chk("nvm", 32'({b, !b}), 32'({nvm_block_o, nvm_grant_o}));
	endtask : nvm

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		rst_b_i = 1'b0;
		nvm_erase_i = 1'b0;
		nvm_req_i = 1'b0;
		nvm_addr_i = 10'h000;
		res_load_i = 8'h00;
		res_data_i = '0;
		res_rd_i = 1'b0;
		res_idx_i = 3'h0;
		failures = 0;
		n_tests = 0;
		unrd = 8'h00;
		for (int i = 0; i < 256; i++) exp_r[i] = 8'h00;
		for (int i = 0; i < 8; i++) slot[i] = 32'h0;
		void'($urandom(32'h7afba20d));
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		for (int a = 8'h20; a < 8'h38; a++) rd(8'(a));
		for (int p = 0; p < 2; p++) begin
			for (int a = 8'h20; a < 8'h38; a++) wr(8'(a), 8'($urandom) | 8'h01);
		end
		for (int a = 8'h20; a < 8'h38; a++) rd(8'(a));
		@(posedge ref_clk_i);
		nvm_erase_i <= 1'b1;
		@(posedge ref_clk_i);
		nvm_erase_i <= 1'b0;
		exp_r[ADDR_SER_LO] = 8'h00;
		exp_r[ADDR_SER_HI] = 8'h00;
		wr(ADDR_SER_LO, 8'h5a);
		wr(ADDR_SER_HI, 8'ha5);
		for (int k = 0; k < 4; k++) wr(ADDR_GAIN, 8'(k * 8'h55));
		for (int k = 0; k < 2; k++) wr(ADDR_ALARM, k ? 8'hff : 8'h00);
		for (int m = 0; m < 5; m++) begin
			wr(ADDR_LOCK, (m < 4) ? 8'(1 << m) : 8'hf0);
			foreach (nb[j]) nvm(nb[j]);
		end
		wr(ADDR_RUN, 8'h01);
		for (int i = 0; i < 8; i++) load(i, $urandom);
		for (int i = 0; i < 8; i++) rres(i);
		for (int c = 0; c < 16; c++) begin
			wr(ADDR_PULSE_SEL, {4'(c), 4'(15 - c)});
			chk("pulse1", (c < 8) ? slot[c] : 32'h0, pulse_if1_data_o);
			chk("pulse0", (c > 7) ? slot[15 - c] : 32'h0, pulse_if0_data_o);
		end
		wr(ADDR_ALARM, 8'h08);
		wr(ADDR_RUN, 8'h01);
		load(2, $urandom);
		load(2, $urandom);
		rres(2);
		load(2, $urandom);
		rres(2);
		wr(ADDR_RUN, 8'h00);
		load(3, $urandom);
		rres(3);
		results();
	end
endmodule : tb
`default_nettype wire
